// ==== design/hsc_pkg.sv ====
// Package for the slot B hot-swap channel configuration block.
// Assumes one 20 MHz clock and an I2C engine that issues byte accesses.
//
// Notes on behaviour
// - 12 V fault time: code times 0.41 ms
// - 3.3 V fault time has its own code
// - Clear 12 V enable drives both gates low
// - 12 V interlock needs output below 100 mV
// - 12 V bleed resistor follows bleed bit
// - 3.3 V runs only with bit and pin
// - 3.3 V interlock needs output below 100 mV
// - 3.3 V bleed resistor follows bleed bit
// - Clear reverse-block bit forces block gate low
// - Pulldown test holds fast turn-off drivers on
// - Latch off, or retry after 100 fault times
// - 3.3 V fault stops 12 V unless disabled
// - 3.3 V retry holds 12 V until toggle
// - Reverse-block bit turns 3.3 V off on reverse
// - Inrush boost uses maximum limit until current drops
// - Slot A mask blocks status bits 3:0
// - Slot B mask blocks status bits 7:4
// - Fault flag sets on expiry, clears on read
// - Power-good flag read-clears only when above threshold
package hsc_pkg;

  localparam int unsigned CLK_PERIOD_NS = 50;
  localparam int unsigned FT_LSB_NS     = 410000;
  localparam int unsigned FT_TICK_CYC   = FT_LSB_NS / CLK_PERIOD_NS;
  localparam int unsigned FAST_OFF_NS   = 15000;
  localparam int unsigned FAST_OFF_CYC  = FAST_OFF_NS / CLK_PERIOD_NS;
  localparam int unsigned RETRY_MULT    = 100;

  localparam logic [7:0] ADDR_RAIL12_B = 8'h04;
  localparam logic [7:0] ADDR_RAIL3_B  = 8'h05;
  localparam logic [7:0] ADDR_SYS      = 8'h06;
  localparam logic [7:0] ADDR_IRQ      = 8'h07;

  localparam logic [7:0] RST_RAIL12_B = 8'h01;
  localparam logic [7:0] RST_RAIL3_B  = 8'h01;
  localparam logic [7:0] RST_SYS      = 8'h00;
  localparam logic [3:0] RST_IRQ_B    = 4'h5;
  localparam int unsigned IRQ_B_LSB   = 4;

  typedef struct packed {
    logic       bleed_connect;
    logic       discharge_interlock;
    logic       master_enable;
    logic [4:0] fault_time_code;
  } hsc_rail_cfg_t;

  typedef struct packed {
    logic cross_shutdown_disable;
    logic slot_b_irq_mask;
    logic slot_a_irq_mask;
    logic nonredundant_inrush_boost;
    logic low_rail_reverse_block_enable;
    logic spare;
    logic retry_after_fault;
    logic pulldown_test;
  } hsc_sys_cfg_t;

  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } hsc_reg_req_t;

  typedef struct packed {
    logic rail12_in_limit;
    logic rail3_in_limit;
    logic rail12_out_low;
    logic rail3_out_low;
    logic rail3_b_enable_pin;
    logic rail3_reverse;
    logic rail12_pg_ok;
    logic rail3_pg_ok;
  } hsc_sense_t;

endpackage

// ==== design/hsc_fault_timer.sv ====
// One channel's fault timer with optional automatic retry.
// Assumes a one-cycle tick every fault-time LSB from the parent.
`timescale 1ns/100ps
`default_nettype none
module hsc_fault_timer #(
  parameter int unsigned RETRY_MULT = 100
) (
  input  wire logic       clock,
  input  wire logic       rst_n,
  input  wire logic       tick,
  input  wire logic       running,
  input  wire logic       enabled,
  input  wire logic       in_limit,
  input  wire logic [4:0] code,
  input  wire logic       retry_mode,
  output logic            expired,
  output logic            tripped,
  output logic            restart
);

  localparam int unsigned RW = $clog2(RETRY_MULT * 32);

  logic [4:0]    cnt_r;
  logic [4:0]    code_eff;
  logic [RW-1:0] rcnt_r;
  logic [RW-1:0] rlen;
  logic          trip_r;

  // Code zero behaves as one LSB so the channel stays protected
  assign code_eff = (code == 5'h00) ? 5'h01 : code;
  assign rlen     = RW'(code_eff) * RW'(RETRY_MULT);
  assign expired  = running && in_limit && tick && (cnt_r == code_eff - 5'h01);
  assign restart  = trip_r && retry_mode && tick && (rcnt_r == rlen - RW'(1));
  assign tripped  = trip_r;

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      cnt_r  <= 5'h00;
      rcnt_r <= '0;
      trip_r <= 1'b0;
    end else begin
      if (!running || !in_limit) begin
        cnt_r <= 5'h00;
      end else if (tick) begin
        cnt_r <= cnt_r + 5'h01;
      end
      if (!trip_r || !retry_mode) begin
        rcnt_r <= '0;
      end else if (tick) begin
        rcnt_r <= rcnt_r + RW'(1);
      end
      if (expired) begin
        trip_r <= 1'b1;
      end else if (restart || !enabled) begin
        trip_r <= 1'b0;
      end
    end
  end

endmodule
`default_nettype wire

// ==== design/hsc_cfg.sv ====
// Slot B channel configuration, gate control and status flags.
// Assumes an I2C engine on this clock giving one-cycle read and write
// strobes, and analog comparators arriving asynchronously on pins.
`timescale 1ns/100ps
`default_nettype none
module hsc_cfg #(
  parameter int unsigned TICK_CYCLES = hsc_pkg::FT_TICK_CYC,
  parameter int unsigned FAST_CYCLES = hsc_pkg::FAST_OFF_CYC
) (
  input  wire logic                clock,
  input  wire logic                rst_n,
  input  wire hsc_pkg::hsc_reg_req_t reg_req,
  output logic [7:0]               rd_data,
  input  wire hsc_pkg::hsc_sense_t sense,
  input  wire logic                rail12_b_reverse_block_enable,
  input  wire logic [3:0]          slot_a_flags,
  output logic                     rail12_b_pass_gate,
  output logic                     rail12_b_block_gate,
  output logic                     rail3_b_gate_drive,
  output logic                     rail12_b_bleed_on,
  output logic                     rail3_b_bleed_on,
  output logic                     rail12_b_fast_off,
  output logic                     pulldown_test_all,
  output logic                     rail12_b_limit_max,
  output logic                     interrupt_out_n
);

  localparam int unsigned TW = $clog2(TICK_CYCLES);
  localparam int unsigned FW = $clog2(FAST_CYCLES + 1);

  ////////////////////////////////////////////////////////////////////
  // Declarations

  hsc_pkg::hsc_rail_cfg_t cfg12_r;
  hsc_pkg::hsc_rail_cfg_t cfg3_r;
  hsc_pkg::hsc_sys_cfg_t  sys_r;
  hsc_pkg::hsc_sense_t    sn_r;
  hsc_pkg::hsc_sense_t    sn_nxt;

  logic [7:0]    s1_r;
  logic [7:0]    s2_r;
  logic [7:0]    s3_r;
  logic [TW-1:0] tick_cnt_r;
  logic          tick;
  logic [FW-1:0] fast_cnt_r;

  logic run12_r;
  logic run12_nxt;
  logic run3_r;
  logic run3_nxt;
  logic blk_r;
  logic gate3_r;
  logic lock12_r;
  logic lock12_nxt;
  logic inrush_r;
  logic inrush_nxt;
  logic seen_r;
  logic seen_nxt;
  logic limit_r;
  logic fast_r;
  logic ptest_r;
  logic bleed12_r;
  logic bleed3_r;
  logic irq_n_r;
  logic [7:0] rd_r;
  logic [7:0] rd_nxt;
  logic [3:0] flag_b_r;
  logic [3:0] flag_b_nxt;

  logic wr12;
  logic wr3;
  logic wrsys;
  logic rdirq;
  logic req12;
  logic req3;
  logic cross_kill;
  logic rev_kill;
  logic exp12;
  logic trip12;
  logic rst12;
  logic exp3;
  logic trip3;
  logic rst3;
  logic fall12;
  logic irq_any;
  logic [7:0] irq_reg;

  ////////////////////////////////////////////////////////////////////
  // Pin synchronisers: three stages, a change counts when 2 and 3 agree

  assign sn_nxt = hsc_pkg::hsc_sense_t'((~(s2_r ^ s3_r) & s3_r)
                | ((s2_r ^ s3_r) & sn_r));

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      s1_r <= 8'h00;
      s2_r <= 8'h00;
      s3_r <= 8'h00;
      sn_r <= '0;
    end else begin
      s1_r <= sense;
      s2_r <= s1_r;
      s3_r <= s2_r;
      sn_r <= sn_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Fault-time base

  // Rounded down: a tick a shade short errs toward faster protection
  assign tick = (tick_cnt_r == TW'(TICK_CYCLES - 1));

  always_ff @(posedge clock) begin
    if (!rst_n || tick) begin
      tick_cnt_r <= '0;
    end else begin
      tick_cnt_r <= tick_cnt_r + TW'(1);
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Register decode

  assign wr12  = reg_req.wr && (reg_req.addr == hsc_pkg::ADDR_RAIL12_B);
  assign wr3   = reg_req.wr && (reg_req.addr == hsc_pkg::ADDR_RAIL3_B);
  assign wrsys = reg_req.wr && (reg_req.addr == hsc_pkg::ADDR_SYS);
  assign rdirq = reg_req.rd && (reg_req.addr == hsc_pkg::ADDR_IRQ);

  assign irq_reg = {flag_b_r, slot_a_flags};

  assign rd_nxt =
      (reg_req.addr == hsc_pkg::ADDR_RAIL12_B) ? cfg12_r :
      (reg_req.addr == hsc_pkg::ADDR_RAIL3_B)  ? cfg3_r  :
      (reg_req.addr == hsc_pkg::ADDR_SYS)      ? sys_r   :
      (reg_req.addr == hsc_pkg::ADDR_IRQ)      ? irq_reg : 8'h00;

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      cfg12_r <= hsc_pkg::RST_RAIL12_B;
      cfg3_r  <= hsc_pkg::RST_RAIL3_B;
      sys_r   <= hsc_pkg::RST_SYS;
      rd_r    <= 8'h00;
    end else begin
      if (wr12) begin
        cfg12_r <= reg_req.wdata;
      end
      if (wr3) begin
        cfg3_r <= reg_req.wdata;
      end
      // Spare bit is stored as written; software keeps it zero
      if (wrsys) begin
        sys_r <= reg_req.wdata;
      end
      if (reg_req.rd) begin
        rd_r <= rd_nxt;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Fault timers

  hsc_fault_timer #(
    .RETRY_MULT (hsc_pkg::RETRY_MULT)
  ) u_timer12 (
    .clock      (clock),
    .rst_n      (rst_n),
    .tick       (tick),
    .running    (run12_r),
    .enabled    (cfg12_r.master_enable),
    .in_limit   (sn_r.rail12_in_limit),
    .code       (cfg12_r.fault_time_code),
    .retry_mode (sys_r.retry_after_fault),
    .expired    (exp12),
    .tripped    (trip12),
    .restart    (rst12)
  );

  hsc_fault_timer #(
    .RETRY_MULT (hsc_pkg::RETRY_MULT)
  ) u_timer3 (
    .clock      (clock),
    .rst_n      (rst_n),
    .tick       (tick),
    .running    (run3_r),
    .enabled    (cfg3_r.master_enable),
    .in_limit   (sn_r.rail3_in_limit),
    .code       (cfg3_r.fault_time_code),
    .retry_mode (sys_r.retry_after_fault),
    .expired    (exp3),
    .tripped    (trip3),
    .restart    (rst3)
  );

  ////////////////////////////////////////////////////////////////////
  // Channel control

  assign cross_kill = trip3 && !sys_r.cross_shutdown_disable;
  assign rev_kill = sys_r.low_rail_reverse_block_enable
                  && sn_r.rail3_reverse;

  assign req12 = cfg12_r.master_enable
               && !trip12
               && !cross_kill
               && !lock12_r
               && !sys_r.pulldown_test;
  // Interlock only gates turn-on; a running rail is not dropped
  assign run12_nxt = req12 && (run12_r || !cfg12_r.discharge_interlock
                   || sn_r.rail12_out_low);

  assign req3 = cfg3_r.master_enable
              && sn_r.rail3_b_enable_pin
              && !trip3
              && !rev_kill;
  assign run3_nxt = req3 && (run3_r || !cfg3_r.discharge_interlock
                  || sn_r.rail3_out_low);

  // Lock set by a 3.3 V retry wins over the enable going low
  assign lock12_nxt = (rst3 && !sys_r.cross_shutdown_disable)
                    || (lock12_r && cfg12_r.master_enable);

  assign fall12 = run12_r && !run12_nxt;

  assign inrush_nxt = (run12_nxt && !run12_r)
                    || (inrush_r && run12_nxt
                    && !(seen_r && !sn_r.rail12_in_limit));
  assign seen_nxt = inrush_nxt && (seen_r || sn_r.rail12_in_limit);

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      run12_r  <= 1'b0;
      run3_r   <= 1'b0;
      blk_r    <= 1'b0;
      gate3_r  <= 1'b0;
      lock12_r <= 1'b0;
      inrush_r <= 1'b0;
      seen_r   <= 1'b0;
      limit_r  <= 1'b0;
    end else begin
      run12_r  <= run12_nxt;
      run3_r   <= run3_nxt;
      blk_r    <= run12_nxt && rail12_b_reverse_block_enable;
      gate3_r  <= run3_nxt;
      lock12_r <= lock12_nxt;
      inrush_r <= inrush_nxt;
      seen_r   <= seen_nxt;
      limit_r  <= inrush_nxt && sys_r.nonredundant_inrush_boost;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Fast turn-off and bleed

  // Drivers are short-lived by design; the test bit defeats the limit
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      fast_cnt_r <= '0;
      fast_r     <= 1'b0;
      ptest_r    <= 1'b0;
      bleed12_r  <= 1'b0;
      bleed3_r   <= 1'b0;
    end else begin
      if (fall12) begin
        fast_cnt_r <= FW'(FAST_CYCLES);
      end else if (fast_cnt_r != '0) begin
        fast_cnt_r <= fast_cnt_r - FW'(1);
      end
      fast_r    <= sys_r.pulldown_test || fall12 || (fast_cnt_r > FW'(1));
      ptest_r   <= sys_r.pulldown_test;
      bleed12_r <= cfg12_r.bleed_connect;
      bleed3_r  <= cfg3_r.bleed_connect;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Slot B status flags and interrupt

  // Order {3.3 fault, 3.3 good, 12 fault, 12 good}; set beats read-clear
  assign flag_b_nxt[0] = !sn_r.rail12_pg_ok
                       || (flag_b_r[0] && !rdirq);
  assign flag_b_nxt[1] = exp12 || (flag_b_r[1] && !rdirq);
  assign flag_b_nxt[2] = !sn_r.rail3_pg_ok
                       || (flag_b_r[2] && !rdirq);
  assign flag_b_nxt[3] = exp3 || (flag_b_r[3] && !rdirq);

  assign irq_any = (|(slot_a_flags & {4{!sys_r.slot_a_irq_mask}}))
                 || (|(flag_b_r & {4{!sys_r.slot_b_irq_mask}}));

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      flag_b_r <= hsc_pkg::RST_IRQ_B;
      irq_n_r  <= 1'b1;
    end else begin
      flag_b_r <= flag_b_nxt;
      irq_n_r  <= !irq_any;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Outputs

  assign rd_data             = rd_r;
  assign rail12_b_pass_gate  = run12_r;
  assign rail12_b_block_gate = blk_r;
  assign rail3_b_gate_drive  = gate3_r;
  assign rail12_b_bleed_on   = bleed12_r;
  assign rail3_b_bleed_on    = bleed3_r;
  assign rail12_b_fast_off   = fast_r;
  assign pulldown_test_all   = ptest_r;
  assign rail12_b_limit_max  = limit_r;
  assign interrupt_out_n     = irq_n_r;

  ////////////////////////////////////////////////////////////////////
  // Assertions

  default clocking @(posedge clock); endclocking
  default disable iff (!rst_n);

  sequence fault3_s;
    trip3 && !sys_r.cross_shutdown_disable;
  endsequence
  sequence retry3_s;
    rst3 && !sys_r.cross_shutdown_disable;
  endsequence

  en_off_a: assert property (
    !cfg12_r.master_enable |=> !rail12_b_pass_gate && !rail12_b_block_gate)
    else $error("12 V gates on while disabled");
  interlock_hold_a: assert property (
    !run12_r && cfg12_r.discharge_interlock && !sn_r.rail12_out_low
    |=> !rail12_b_pass_gate)
    else $error("12 V turned on above bleed threshold");
  bleed_follow_a: assert property (
    ##1 rail12_b_bleed_on == $past(cfg12_r.bleed_connect)
    && rail3_b_bleed_on == $past(cfg3_r.bleed_connect))
    else $error("bleed output does not follow its bit");
  pin_gate_a: assert property (
    !(cfg3_r.master_enable && sn_r.rail3_b_enable_pin)
    |=> !rail3_b_gate_drive)
    else $error("3.3 V gate on without bit and pin");
  block_low_a: assert property (
    !rail12_b_reverse_block_enable |=> !rail12_b_block_gate)
    else $error("block gate on with reverse block clear");
  ptest_fast_a: assert property (
    sys_r.pulldown_test [*2] |=> rail12_b_fast_off && pulldown_test_all)
    else $error("fast turn-off not held in pulldown test");
  cross_off_a: assert property (
    fault3_s |=> !rail12_b_pass_gate)
    else $error("12 V runs after paired 3.3 V fault");
  retry_lock_a: assert property (
    retry3_s ##1 cfg12_r.master_enable [*3] |=> !rail12_b_pass_gate)
    else $error("12 V restarted without enable toggle");
  rev_off_a: assert property (
    rev_kill |=> !rail3_b_gate_drive)
    else $error("3.3 V on during reverse block");
  mask_irq_a: assert property (
    sys_r.slot_a_irq_mask && (flag_b_r == 4'h0) |=> interrupt_out_n)
    else $error("interrupt asserted from masked slot A flags");
  fault_flag_a: assert property (
    exp12 |=> flag_b_r[1] && $rose(trip12))
    else $error("12 V fault flag missed timer expiry");
  pg_hold_a: assert property (
    flag_b_r[0] && !sn_r.rail12_pg_ok && rdirq |=> flag_b_r[0])
    else $error("power-good flag cleared while below threshold");

endmodule
`default_nettype wire

// ==== test/hsc_host_model.sv ====
// Host-side model that issues single-byte register accesses to the block.
// Assumes one-cycle strobes sampled on the rising edge and read data one edge later.
`timescale 1ns/100ps
`default_nettype none
module hsc_host_model (
  input  wire logic                  clock,
  input  wire logic [7:0]            rd_data,
  output var  hsc_pkg::hsc_reg_req_t reg_req
);

  initial begin
    reg_req = '0;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Strobe for one edge, then a free edge before any new strobe
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic [7:0] v;
    v = d;
    if (a == hsc_pkg::ADDR_SYS) begin
      v[2] = 1'b0;
    end
    @(posedge clock);
    reg_req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: v};
    @(posedge clock);
    reg_req.wr <= 1'b0;
  endtask

  // Data taken one full edge after the strobe edge, never in the race
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clock);
    reg_req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
    @(posedge clock);
    reg_req.rd <= 1'b0;
    @(posedge clock);
    #1;
    d = rd_data;
  endtask

endmodule
`default_nettype wire

// ==== test/hot_swap_channel_config_test.sv ====
// Self-checking bench for the slot B channel configuration block.
// Assumes a short tick parameter; sense pins are driven straight by the bench.
`timescale 1ns/100ps
`default_nettype none
module hot_swap_channel_config_test;

  localparam int unsigned T = 8;
  logic                  clock = 1'b0;
  logic                  rst_n = 1'b0;
  hsc_pkg::hsc_reg_req_t reg_req;
  hsc_pkg::hsc_sense_t   sense = 8'h03;
  logic                  rail12_b_reverse_block_enable = 1'b0;
  logic [3:0]            slot_a_flags = 4'h0;
  logic [7:0]            rd_data;
  logic                  rail12_b_pass_gate, rail12_b_block_gate, rail3_b_gate_drive;
  logic                  rail12_b_bleed_on, rail3_b_bleed_on, rail12_b_fast_off;
  logic                  pulldown_test_all, rail12_b_limit_max, interrupt_out_n;
  int                    error_cnt = 0;
  int                    n_tests = 0;
  integer                seed = 32'h1C60;
  int                    rnd;
  int                    n;
  logic [7:0]            r, d;
  logic [4:0]            c;
  string pn [9] = '{"pass", "block", "gate3", "bleed12", "bleed3", "fast_off", "pdtest",
                    "limit_max", "irq_n"};

  always #25 clock = ~clock;

  hsc_cfg #(.TICK_CYCLES(T), .FAST_CYCLES(5)) dut_u (
    .clock, .rst_n, .reg_req, .rd_data, .sense, .rail12_b_reverse_block_enable,
    .slot_a_flags, .rail12_b_pass_gate, .rail12_b_block_gate, .rail3_b_gate_drive,
    .rail12_b_bleed_on, .rail3_b_bleed_on, .rail12_b_fast_off, .pulldown_test_all,
    .rail12_b_limit_max, .interrupt_out_n
  );

  hsc_host_model host_u (.clock, .rd_data, .reg_req);

  ////////////////////////////////////////////////////////////////////////////////
  function automatic logic pin(input int i);
    logic [8:0] v;
    v = {interrupt_out_n, rail12_b_limit_max, pulldown_test_all, rail12_b_fast_off,
         rail3_b_bleed_on, rail12_b_bleed_on, rail3_b_gate_drive, rail12_b_block_gate,
         rail12_b_pass_gate};
    return v[i];
  endfunction

  task automatic summarize();
    $display("comparisons %0d mismatches %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  task automatic chk_byte(input logic [7:0] a, input logic [7:0] e);
    logic [7:0] s;
    host_u.rd(a, s);
    n_tests++;
    if (s !== e) begin
      error_cnt++;
      $display("CHECK FAILED reg %h exp %h seen %h", a, e, s);
    end
  endtask

  task automatic chk_pin(input int i, input logic e);
    n_tests++;
    if (pin(i) !== e) begin
      error_cnt++;
      $display("CHECK FAILED %s exp %b seen %b", pn[i], e, pin(i));
    end
  endtask

  task automatic chk_cnt(input string nm, input int v, input int lo, input int hi);
    n_tests++;
    if (v < lo || v > hi) begin
      error_cnt++;
      $display("CHECK FAILED %s exp %0d..%0d seen %0d", nm, lo, hi, v);
    end
  endtask

  // Bounded poll; running out ends the run as a mismatch
  task automatic wait_pin(input int i, input logic v, input int lim, output int k);
    k = 0;
    while (pin(i) !== v && k < lim) begin
      @(posedge clock);
      #1;
      k++;
    end
    if (k >= lim) begin
      error_cnt++;
      $display("CHECK FAILED %s wait exp %b seen %b", pn[i], v, pin(i));
      summarize();
    end
  endtask

  // Covers the four-edge sense filter plus the output register
  task automatic settle();
    repeat (8) @(posedge clock);
    #1;
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (4) @(posedge clock);
    rst_n <= 1'b1;
    @(posedge clock);
    #1;
    chk_byte(8'h04, 8'h01);
    chk_byte(8'h05, 8'h01);
    chk_byte(8'h06, 8'h00);
    chk_byte(8'h08, 8'h00);
    chk_pin(8, 1'b0);
    host_u.wr(8'h06, 8'h40);
    settle();
    chk_pin(8, 1'b1);
    host_u.wr(8'h06, 8'h00);
    chk_byte(8'h07, 8'h50);
    chk_byte(8'h07, 8'h00);
    settle();
    chk_pin(8, 1'b1);
    rnd = $random(seed);
    @(posedge clock) slot_a_flags <= rnd[3:0] | 4'h1;
    settle();
    chk_pin(8, 1'b0);
    host_u.wr(8'h06, 8'h20);
    settle();
    chk_pin(8, 1'b1);
    host_u.wr(8'h07, 8'hFF);
    chk_byte(8'h07, {4'h0, slot_a_flags});
    @(posedge clock) slot_a_flags <= 4'h0;
    $display("test reset_irq done");
    for (int i = 0; i < 8; i++) begin
      rnd = $random(seed);
      r = 8'h04 + ((rnd[9:8] == 2'h3) ? 8'h00 : {6'h00, rnd[9:8]});
      d = rnd[7:0];
      host_u.wr(r, d);
      if (r == 8'h06) d[2] = 1'b0;
      chk_byte(r, d);
    end
    host_u.wr(8'h04, 8'h01);
    host_u.wr(8'h05, 8'h01);
    host_u.wr(8'h06, 8'h00);
    $display("test readback done");
    host_u.wr(8'h04, 8'hA1);
    settle();
    chk_pin(0, 1'b1);
    chk_pin(1, 1'b0);
    chk_pin(3, 1'b1);
    @(posedge clock) rail12_b_reverse_block_enable <= 1'b1;
    settle();
    chk_pin(1, 1'b1);
    host_u.wr(8'h04, 8'h01);
    settle();
    chk_pin(0, 1'b0);
    chk_pin(1, 1'b0);
    chk_pin(3, 1'b0);
    $display("test rail12 gates done");
    for (int i = 0; i < 4; i++) begin
      @(posedge clock) sense.rail3_b_enable_pin <= i[1];
      host_u.wr(8'h05, {i[0], 1'b0, i[0], 5'h01});
      settle();
      chk_pin(2, i[0] & i[1]);
      chk_pin(4, i[0]);
    end
    host_u.wr(8'h06, 8'h08);
    @(posedge clock) sense.rail3_reverse <= 1'b1;
    settle();
    chk_pin(2, 1'b0);
    host_u.wr(8'h06, 8'h00);
    settle();
    chk_pin(2, 1'b1);
    @(posedge clock) sense.rail3_reverse <= 1'b0;
    $display("test rail3 gate done");
    host_u.wr(8'h05, 8'h00);
    host_u.wr(8'h04, 8'h61);
    settle();
    chk_pin(0, 1'b0);
    @(posedge clock) sense.rail12_out_low <= 1'b1;
    settle();
    chk_pin(0, 1'b1);
    host_u.wr(8'h05, 8'h61);
    settle();
    chk_pin(2, 1'b0);
    @(posedge clock) sense.rail3_out_low <= 1'b1;
    settle();
    chk_pin(2, 1'b1);
    host_u.wr(8'h05, 8'h01);
    host_u.wr(8'h04, 8'h21);
    $display("test interlock done");
    host_u.wr(8'h06, 8'h01);
    repeat (20) @(posedge clock);
    #1;
    chk_pin(6, 1'b1);
    chk_pin(5, 1'b1);
    chk_pin(0, 1'b0);
    host_u.wr(8'h06, 8'h00);
    settle();
    chk_pin(5, 1'b0);
    chk_pin(0, 1'b1);
    host_u.wr(8'h04, 8'h01);
    host_u.wr(8'h06, 8'h10);
    host_u.wr(8'h04, 8'h3F);
    settle();
    chk_pin(7, 1'b1);
    @(posedge clock) sense.rail12_in_limit <= 1'b1;
    settle();
    chk_pin(7, 1'b1);
    @(posedge clock) sense.rail12_in_limit <= 1'b0;
    settle();
    chk_pin(7, 1'b0);
    host_u.wr(8'h06, 8'h00);
    host_u.wr(8'h04, 8'h01);
    $display("test pulldown_inrush done");
    for (int k = 0; k < 2; k++) begin
      rnd = $random(seed);
      c = (k == 0) ? 5'h01 : 5'h02 + {3'h0, rnd[1:0]};
      host_u.wr(8'h04, {3'b001, c});
      settle();
      chk_pin(0, 1'b1);
      @(posedge clock) sense.rail12_in_limit <= 1'b1;
      wait_pin(0, 1'b0, 1000, n);
      chk_cnt("trip time", n, (c - 1) * T + 3, c * T + 10);
      @(posedge clock) sense.rail12_in_limit <= 1'b0;
      repeat (40) @(posedge clock);
      #1;
      chk_pin(0, 1'b0);
      chk_pin(8, 1'b0);
      chk_byte(8'h07, 8'h20);
      chk_byte(8'h07, 8'h00);
      host_u.wr(8'h04, 8'h01);
    end
    host_u.wr(8'h06, 8'h02);
    host_u.wr(8'h04, 8'h21);
    settle();
    @(posedge clock) sense.rail12_in_limit <= 1'b1;
    wait_pin(0, 1'b0, 100, n);
    @(posedge clock) sense.rail12_in_limit <= 1'b0;
    wait_pin(0, 1'b1, 1000, n);
    chk_cnt("retry time", n, 98 * T, 102 * T + 10);
    chk_byte(8'h07, 8'h20);
    $display("test fault timer done");
    host_u.wr(8'h05, 8'h22);
    settle();
    chk_pin(2, 1'b1);
    @(posedge clock) sense.rail3_in_limit <= 1'b1;
    wait_pin(2, 1'b0, 200, n);
    chk_cnt("rail3 trip time", n, T + 3, 2 * T + 10);
    settle();
    chk_pin(0, 1'b0);
    @(posedge clock) sense.rail3_in_limit <= 1'b0;
    wait_pin(2, 1'b1, 2000, n);
    settle();
    chk_pin(0, 1'b0);
    host_u.wr(8'h04, 8'h01);
    host_u.wr(8'h04, 8'h21);
    settle();
    chk_pin(0, 1'b1);
    host_u.wr(8'h06, 8'h80);
    @(posedge clock) sense.rail3_in_limit <= 1'b1;
    wait_pin(2, 1'b0, 200, n);
    settle();
    chk_pin(0, 1'b1);
    $display("test cross shutdown done");
    @(posedge clock) sense.rail12_pg_ok <= 1'b0;
    settle();
    chk_byte(8'h07, 8'h90);
    chk_byte(8'h07, 8'h10);
    @(posedge clock) sense.rail12_pg_ok <= 1'b1;
    settle();
    chk_byte(8'h07, 8'h10);
    chk_byte(8'h07, 8'h00);
    $display("test status flags done");
    summarize();
  end

endmodule
`default_nettype wire
